// file: hw/nand_ctl_consts.vh
/*
 * constants of the nand command sequencer: command codes, status and id
 * field positions, timing counts at a 50 MHz core clock.
 * assumes inclusion by bare name from the design file.
 */
`ifndef NAND_CTL_CONSTS_VH
`define NAND_CTL_CONSTS_VH

// command codes
`define CMD_ERASE_SETUP   8'h60
`define CMD_ERASE_CONFIRM 8'hD0
`define CMD_STATUS        8'h70
`define CMD_DIST_STATUS   8'h71
`define CMD_READ_ID       8'h90
`define CMD_RESET         8'hFF
`define ID_ADDR           8'h00

// status byte fields
`define ST_RESULT_BIT     0
`define ST_PREV_BIT       1
`define ST_D0_BIT         1
`define ST_D1_BIT         2
`define ST_PB_READY_BIT   5
`define ST_DC_READY_BIT   6
`define ST_WP_BIT         7

// id byte fields (lsb of each two-bit code)
`define ID3_CHIPS_LSB     1
`define ID3_CELL_LSB      3
`define ID4_PAGE_LSB      1
`define ID4_BLOCK_LSB     5
`define ID4_WIDTH_BIT     7
`define ID5_DIST_LSB      3
`define ID_BYTES          3'd5

// control register offsets (byte addresses)
`define REG_CTRL          8'h00
`define REG_BLOCK0        8'h04
`define REG_BLOCK1        8'h08
`define REG_STATUS        8'h0C
`define REG_ID_LO         8'h10
`define REG_ID_HI         8'h14

// control word bits
`define CTRL_GO_BIT       0
`define CTRL_OP_LSB       1
`define CTRL_TWO_BIT      4

// operation codes
`define OP_ERASE          3'd0
`define OP_STATUS         3'd1
`define OP_ID             3'd2
`define OP_RESET          3'd3
`define OP_DIST_STATUS    3'd4

// pin timing: half strobe period in ns, and cycles at 20 ns
`define STROBE_NS         40
`define CLK_NS            20
`define STROBE_CYC        ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// file: hw/nand_status_id_erase_ctl.v
/*
 * host side controller for the nand erase, status, id and reset commands.
 * software writes orders over classic wishbone; the controller drives the
 * flash pins and gathers the answers into readable registers.
 * assumes one 50 MHz clock and flash outputs already synchronous to it.
 */
// The register addresses and the Wishbone register port were chosen for this implementation.
`default_nettype none
`include "nand_ctl_consts.vh"

// Function
// - one block per district, setup code each, confirm
// - end with confirm; abandon with reset code
// - status byte read per strobe; bits 3-4 zero
// - pass/fail used only after ready program/erase
// - shared ready line: poll status per device
// - two-district erase result via district status
// - only status or reset codes while busy
// - even/odd districts, same half paired
module nand_status_id_erase_ctl #(
    parameter STROBE = `STROBE_CYC
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        srst,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // flash pins
    output reg         chip_enable_n,
    output reg         cmd_latch,
    output reg         addr_latch,
    output reg         write_strobe_n,
    output reg         read_strobe_n,
    output reg  [7:0]  io_out,
    output reg         io_oe,
    input  wire [7:0]  io_in,
    input  wire        ready_busy_line
);

    localparam S_IDLE = 3'd0;
    localparam S_SETUP = 3'd1;
    localparam S_PULSE = 3'd2;
    localparam S_HOLD = 3'd3;
    localparam S_NEXT = 3'd4;
    localparam S_RD_LO = 3'd5;
    localparam S_RD_HI = 3'd6;
    localparam S_WAIT = 3'd7;

    // kinds of pin cycle
    localparam K_CMD = 2'd0;
    localparam K_ADDR = 2'd1;

    reg  [2:0]  state;
    reg  [2:0]  op;
    reg         two;
    reg  [11:0] block0;
    reg  [11:0] block1;
    reg  [3:0]  step;
    reg  [7:0]  timer;
    reg  [7:0]  status_byte;
    reg  [39:0] id_bytes;
    reg  [2:0]  id_count;
    reg         busy;
    reg         order_bad;
    reg  [7:0]  pin_byte;
    reg  [1:0]  pin_kind;
    reg         pin_last;
    wire        access;
    wire        go;

    assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign go = access & wb_we_i & (wb_adr_i == `REG_CTRL) & wb_sel_i[0] & wb_dat_i[`CTRL_GO_BIT];

    // block address byte: low or high half of a 12-bit block number
    function [7:0] blk_byte;
        input [11:0] blk;
        input        hi;
        begin
            blk_byte = hi ? {4'h0, blk[11:8]} : blk[7:0];
        end
    endfunction

    // sequence table: byte, kind and last flag for each step of an order
    always @*
    begin
        pin_byte = `CMD_RESET;
        pin_kind = K_CMD;
        pin_last = 1'b1;
        case (op)
            `OP_ERASE:
            begin
                // each block after its own setup code, confirm at the end
                case (step)
                    4'd0: pin_byte = `CMD_ERASE_SETUP;
                    4'd1:
                    begin
                        pin_byte = blk_byte(block0, 1'b0);
                        pin_kind = K_ADDR;
                    end
                    4'd2:
                    begin
                        pin_byte = blk_byte(block0, 1'b1);
                        pin_kind = K_ADDR;
                    end
                    4'd3: pin_byte = two ? `CMD_ERASE_SETUP : `CMD_ERASE_CONFIRM;
                    4'd4:
                    begin
                        pin_byte = blk_byte(block1, 1'b0);
                        pin_kind = K_ADDR;
                    end
                    4'd5:
                    begin
                        pin_byte = blk_byte(block1, 1'b1);
                        pin_kind = K_ADDR;
                    end
                    default: pin_byte = `CMD_ERASE_CONFIRM;
                endcase
                pin_last = two ? (step == 4'd6) : (step == 4'd3);
            end
            `OP_ID:
            begin
                pin_byte = (step == 4'd0) ? `CMD_READ_ID : `ID_ADDR;
                pin_kind = (step == 4'd0) ? K_CMD : K_ADDR;
                pin_last = (step == 4'd1);
            end
            `OP_STATUS: pin_byte = `CMD_STATUS;
            `OP_DIST_STATUS: pin_byte = `CMD_DIST_STATUS;
            default: pin_byte = `CMD_RESET;
        endcase
    end

    // pin sequencer
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            state <= S_IDLE;
            op <= `OP_RESET;
            two <= 1'b0;
            block0 <= 12'h000;
            block1 <= 12'h000;
            step <= 4'h0;
            timer <= 8'h00;
            status_byte <= 8'h00;
            id_bytes <= 40'h0;
            id_count <= 3'd0;
            busy <= 1'b0;
            order_bad <= 1'b0;
            chip_enable_n <= 1'b1;
            cmd_latch <= 1'b0;
            addr_latch <= 1'b0;
            write_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            io_out <= 8'h00;
            io_oe <= 1'b0;
        end
        else
        begin
            if (timer != 8'h00)
                timer <= timer - 8'h01;
            if (access & wb_we_i & (wb_adr_i == `REG_BLOCK0) & ~busy)
                block0 <= wb_dat_i[11:0];
            if (access & wb_we_i & (wb_adr_i == `REG_BLOCK1) & ~busy)
                block1 <= wb_dat_i[11:0];
            case (state)
                S_IDLE:
                begin
                    if (go)
                    begin
                        op <= wb_dat_i[`CTRL_OP_LSB +: 3];
                        two <= wb_dat_i[`CTRL_TWO_BIT];
                        // while the flash is busy only status or reset may go out
                        if (~ready_busy_line & (wb_dat_i[`CTRL_OP_LSB +: 3] == `OP_ERASE ||
                                                wb_dat_i[`CTRL_OP_LSB +: 3] == `OP_ID))
                            order_bad <= 1'b1;
                        else if (wb_dat_i[`CTRL_OP_LSB +: 3] == `OP_ERASE && wb_dat_i[`CTRL_TWO_BIT] &&
                                 (block0[0] == block1[0] || block0[11] != block1[11]))
                            order_bad <= 1'b1;
                        else
                        begin
                            order_bad <= 1'b0;
                            busy <= 1'b1;
                            step <= 4'h0;
                            id_count <= 3'd0;
                            chip_enable_n <= 1'b0;
                            state <= S_SETUP;
                        end
                    end
                end
                S_SETUP:
                begin
                    // present byte and latch level and drop write strobe in the same cycle
                    io_out <= pin_byte;
                    io_oe <= 1'b1;
                    cmd_latch <= (pin_kind == K_CMD);
                    addr_latch <= (pin_kind == K_ADDR);
                    write_strobe_n <= 1'b0;
                    timer <= STROBE[7:0];
                    state <= S_PULSE;
                end
                S_PULSE:
                    if (timer == 8'h00)
                    begin
                        write_strobe_n <= 1'b1;
                        timer <= STROBE[7:0];
                        state <= S_HOLD;
                    end
                S_HOLD:
                    if (timer == 8'h00)
                    begin
                        cmd_latch <= 1'b0;
                        addr_latch <= 1'b0;
                        io_oe <= 1'b0;
                        state <= S_NEXT;
                    end
                S_NEXT:
                    if (!pin_last)
                    begin
                        step <= step + 4'h1;
                        state <= S_SETUP;
                    end
                    else if (op == `OP_STATUS || op == `OP_DIST_STATUS || op == `OP_ID)
                    begin
                        timer <= STROBE[7:0];
                        state <= S_RD_LO;
                    end
                    else
                        state <= S_WAIT; // erase and reset: wait for ready
                S_RD_LO:
                begin
                    read_strobe_n <= 1'b0;
                    if (timer == 8'h00)
                    begin
                        // sample at the end of the low phase
                        if (op == `OP_ID)
                            id_bytes <= {io_in, id_bytes[39:8]};
                        else
                            status_byte <= io_in;
                        id_count <= id_count + 3'd1;
                        read_strobe_n <= 1'b1;
                        timer <= STROBE[7:0];
                        state <= S_RD_HI;
                    end
                end
                S_RD_HI:
                    if (timer == 8'h00)
                    begin
                        if (op == `OP_ID && id_count != `ID_BYTES)
                        begin
                            timer <= STROBE[7:0];
                            state <= S_RD_LO;
                        end
                        else
                        begin
                            chip_enable_n <= 1'b1;
                            busy <= 1'b0;
                            state <= S_IDLE;
                        end
                    end
                S_WAIT:
                    // the shared line may stay low for other chips; software polls status
                    if (ready_busy_line)
                    begin
                        chip_enable_n <= 1'b1;
                        busy <= 1'b0;
                        state <= S_IDLE;
                    end
                default: state <= S_IDLE;
            endcase
        end
    end

    // wishbone answer: one wait cycle, ack for one cycle
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= access;
            wb_dat_o <= 32'h0;
            if (access & ~wb_we_i)
            begin
                case (wb_adr_i)
                    `REG_CTRL: wb_dat_o <= {27'h0, two, op, 1'b0};
                    `REG_BLOCK0: wb_dat_o <= {20'h0, block0};
                    `REG_BLOCK1: wb_dat_o <= {20'h0, block1};
                    // pass/fail bits only meaningful once ready after program/erase
                    `REG_STATUS: wb_dat_o <= {14'h0, order_bad, busy, 8'h00, status_byte};
                    `REG_ID_LO: wb_dat_o <= id_bytes[31:0];
                    `REG_ID_HI: wb_dat_o <= {24'h0, id_bytes[39:32]};
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

endmodule // nand_status_id_erase_ctl
`default_nettype wire

// file: tb/nand_status_id_erase_ctl_assertions.sv
/* port checker for the nand erase, status, id and reset controller.
   assumes a bind onto the controller, one clock and a sync reset. */
`default_nettype none
`include "nand_ctl_consts.vh"
module nand_ctl_checker #(
    parameter int STROBE = 2
) (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       srst,
    // wishbone handshake
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    // flash pins
    input wire logic       chip_enable_n,
    input wire logic       cmd_latch,
    input wire logic       addr_latch,
    input wire logic       write_strobe_n,
    input wire logic       read_strobe_n,
    input wire logic [7:0] io_out,
    input wire logic       io_oe,
    input wire logic       ready_busy_line
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    logic [3:0] re_low;
    // low cycles of the current read strobe
    always_ff @(posedge core_clk)
    begin
        re_low <= (srst || read_strobe_n) ? 4'h0 : re_low + 4'h1;
    end
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    AST_PIN_IDLE: assert property (chip_enable_n |-> write_strobe_n && read_strobe_n && !io_oe && !cmd_latch && !addr_latch)
        else $error("pin active while deselected");
    AST_LATCH_EXCL: assert property (!(cmd_latch && addr_latch))
        else $error("both latches high");
    AST_READ_RELEASE: assert property (!read_strobe_n |-> !io_oe)
        else $error("bus driven during read strobe");
    AST_WRITE_HOLD: assert property (!$past(write_strobe_n) |-> $stable(io_out) && $stable(cmd_latch) && io_oe)
        else $error("byte moved around write strobe");
    AST_BUSY_CMDS: assert property ($rose(write_strobe_n) && cmd_latch && !ready_busy_line |->
        io_out inside {`CMD_STATUS, `CMD_DIST_STATUS, `CMD_RESET})
        else $error("forbidden command while busy");
    AST_READ_LEN: assert property ($rose(read_strobe_n) |-> re_low == 4'(STROBE))
        else $error("read strobe length wrong");
    AST_ID_ADDR: assert property ($rose(write_strobe_n) && cmd_latch && io_out == `CMD_READ_ID |->
        ##[1:30] ($rose(write_strobe_n) && addr_latch && io_out == `ID_ADDR))
        else $error("id command without its address");
endmodule // nand_ctl_checker
bind nand_status_id_erase_ctl nand_ctl_checker #(.STROBE(STROBE)) chk (.core_clk(core_clk), .srst(srst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .chip_enable_n(chip_enable_n),
    .cmd_latch(cmd_latch), .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe(io_oe), .ready_busy_line(ready_busy_line));
`default_nettype wire

// file: tb/nand_flash_model.sv
/* behavioural flash device answering erase, status, id and reset codes.
   assumes controller pins registered on core_clk; busy time counted in clocks. */
`default_nettype none
module nand_flash_model #(
    parameter int BUSY_CYC = 40
) (
    // timing reference
    input  wire logic        core_clk,
    // controller pins
    input  wire logic        chip_enable_n,
    input  wire logic        cmd_latch,
    input  wire logic        addr_latch,
    input  wire logic        write_strobe_n,
    input  wire logic        read_strobe_n,
    input  wire logic [7:0]  io_out,
    output var  logic [7:0]  io_in,
    output wire logic        ready_busy_line,
    // bench controls and observations
    input  wire logic        write_protect_n,
    input  wire logic [1:0]  fail,
    output var  logic [31:0] addr_log,
    output var  logic [3:0]  erase_cnt,
    output var  logic [3:0]  reset_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
    localparam logic [7:0] DEVID = 8'hC3; // arbitrary value
    // 4 chips, 4-level cells, 4 KB page, 256 KB block, x8, 2 districts
    localparam logic [39:0] ID = {8'h04, 8'h22, 8'h06, DEVID, MAKER};
    logic [7:0] cmd = 8'h00;
    logic [2:0] idx = 3'h0;
    logic [1:0] res = 2'h0;
    logic       wr_q = 1'b1;
    logic       rd_q = 1'b1;
    int         busy = 0;
    wire logic  rdy = (busy == 0);
    wire logic  wr_rise = !chip_enable_n && write_strobe_n && !wr_q;
    // pull-up holds the line high whenever not busy
    assign ready_busy_line = rdy;
    // no cache ops, so both ready bits agree and the previous-page bit stays 0
    // eight bits: protect, two ready bits, two unused, district results (71 only), combined result
    wire logic [7:0] st = {write_protect_n, rdy, rdy, 2'b00, (cmd == 8'h71) ? res : 2'b00, |res};
    initial
    begin
        io_in = 8'h00;
        addr_log = 32'h0;
        erase_cnt = 4'h0;
        reset_cnt = 4'h0;
    end
    // command, address and read handling
    always @(posedge core_clk)
    begin
        wr_q <= write_strobe_n;
        rd_q <= read_strobe_n;
        if (busy != 0)
            busy <= busy - 1;
        if (wr_rise && cmd_latch)
        begin
            cmd <= io_out;
            idx <= 3'h0;
            if (io_out == 8'hFF)
            begin
                busy <= BUSY_CYC / 4;
                reset_cnt <= reset_cnt + 4'h1;
            end
            if (io_out == 8'hD0)
            begin
                busy <= BUSY_CYC;
                res <= fail;
                erase_cnt <= erase_cnt + 4'h1;
            end
        end
        // any district order, no relation between the blocks
        if (wr_rise && addr_latch)
            addr_log <= {addr_log[23:0], io_out};
        if (!chip_enable_n && !read_strobe_n && rd_q)
        begin
            io_in <= (cmd == 8'h70 || cmd == 8'h71) ? st : ID[idx * 8 +: 8];
            idx <= idx + 3'h1;
        end
        // released bus shows the inverse so stale data never matches
        if (read_strobe_n && !rd_q)
            io_in <= ~io_in;
    end
endmodule // nand_flash_model
`default_nettype wire

// file: tb/nand_status_id_erase_ctl_bench.sv
/* self-checking bench for the nand command controller over wishbone.
   assumes the flash model on the pins and the checker bound by its own file. */
`default_nettype none
`include "nand_ctl_consts.vh"
module nand_status_id_erase_ctl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic        write_protect_n = 1'b1;
    logic [1:0]  fail = 2'h0;
    wire  logic  wb_ack_o, chip_enable_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n, io_oe, ready_busy_line;
    wire  logic [31:0] wb_dat_o, addr_log;
    wire  logic [7:0]  io_out, io_in;
    wire  logic [3:0]  erase_cnt, reset_cnt;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    nand_status_id_erase_ctl uut (.core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .chip_enable_n(chip_enable_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe(io_oe),
        .io_in(io_in), .ready_busy_line(ready_busy_line));
    nand_flash_model #(.BUSY_CYC(40)) flash (.core_clk(core_clk), .chip_enable_n(chip_enable_n),
        .cmd_latch(cmd_latch), .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n), .io_out(io_out), .io_in(io_in), .ready_busy_line(ready_busy_line),
        .write_protect_n(write_protect_n), .fail(fail), .addr_log(addr_log), .erase_cnt(erase_cnt),
        .reset_cnt(reset_cnt));
    always #10 core_clk = ~core_clk;
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // hang guard: the whole run needs a few hundred cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_total++;
            give_verdict();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack is seen at an edge
    task automatic wb(input logic [7:0] adr, input logic we, input logic [31:0] dat, output logic [31:0] q);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        // no answer time assumed: only the bench timeout ends this wait
        while (wb_ack_o !== 1'b1)
            @(posedge core_clk);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    // start an order and poll until the sequencer is idle again
    task automatic run(input logic [2:0] op, input logic two, output logic [31:0] st);
        wb(`REG_CTRL, 1'b1, {27'h0, two, op, 1'b1}, st);
        do
            wb(`REG_STATUS, 1'b0, 32'h0, st);
        while (st[16] !== 1'b0);
    endtask
    task automatic t_idle;
        logic [31:0] q;
        check({29'h0, chip_enable_n, io_oe, wb_ack_o}, 32'h4);
        wb(8'h40, 1'b1, 32'hFFFF_FFFF, q);
        wb(8'h40, 1'b0, 32'h0, q);
        check(q, 32'h0);
    endtask
    task automatic t_id;
        logic [31:0] q;
        run(`OP_ID, 1'b0, q);
        wb(`REG_ID_LO, 1'b0, 32'h0, q);
        check(q, {8'h22, 8'h06, 8'hC3, 8'h5A});
        wb(`REG_ID_HI, 1'b0, 32'h0, q);
        check(q & 32'hFF, 32'h04);
    endtask
    task automatic t_status;
        logic [31:0] q;
        for (int w = 0; w < 2; w++)
        begin
            @(posedge core_clk);
            write_protect_n <= w[0];
            run(`OP_STATUS, 1'b0, q);
            check(q & 32'h3_00FF, {24'h0, w[0], 7'h60});
        end
    endtask
    // district 1 named first, blocks unrelated, district 0 fails
    task automatic t_erase2;
        logic [31:0] q;
        fail <= 2'b01;
        wb(`REG_BLOCK0, 1'b1, 32'h003, q);
        wb(`REG_BLOCK1, 1'b1, 32'h010, q);
        run(`OP_ERASE, 1'b1, q);
        check(q & 32'h2_0000, 32'h0);
        check(addr_log, 32'h0300_1000);
        check({28'h0, erase_cnt}, 32'h1);
        run(`OP_DIST_STATUS, 1'b0, q);
        check(q & 32'hFF, 32'hE3);
        run(`OP_STATUS, 1'b0, q);
        check(q & 32'hFF, 32'hE1);
    endtask
    // same district, then blocks from different halves
    task automatic t_refuse;
        logic [31:0] q;
        wb(`REG_BLOCK0, 1'b1, 32'h002, q);
        wb(`REG_BLOCK1, 1'b1, 32'h004, q);
        run(`OP_ERASE, 1'b1, q);
        check(q & 32'h2_0000, 32'h2_0000);
        wb(`REG_BLOCK1, 1'b1, 32'h803, q);
        run(`OP_ERASE, 1'b1, q);
        check(q & 32'h2_0000, 32'h2_0000);
        wb(`REG_BLOCK1, 1'b0, 32'h0, q);
        check(q, 32'h803);
        check({28'h0, erase_cnt}, 32'h1);
    endtask
    task automatic t_reset;
        logic [31:0] q;
        run(`OP_RESET, 1'b0, q);
        check({28'h0, reset_cnt}, 32'h1);
        check({31'h0, ready_busy_line}, 32'h1);
    endtask
    initial
    begin
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_idle();
        t_id();
        t_status();
        t_erase2();
        t_refuse();
        t_reset();
        give_verdict();
    end
endmodule // nand_status_id_erase_ctl_bench
`default_nettype wire
